// file: bench/ppp_port_monitor.sv
`timescale 1ns/1ps
module ppp_port_monitor #(
    parameter int BUSY_CYC = 64
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_prog_voltage,
    input wire logic i_action_select_hi,
    input wire logic i_action_select_lo,
    input wire logic i_byte_select_a,
    input wire logic i_page_latch_strobe,
    input wire logic i_wr_n,
    input wire logic i_oe_n,
    input wire logic o_data_oe_n,
    input wire logic o_ready_flag,
    input wire logic o_prog_mode
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    logic [7:0] wr_age_r;
    logic [7:0] wr_age_nxt;
    // Both counters saturate so a long idle never wraps into a false hit
    always_comb begin
        low_cnt_nxt = (o_ready_flag || low_cnt_r == 8'hff) ?
                      {8{~o_ready_flag}} & low_cnt_r : low_cnt_r + 8'h01;
        low_cnt_nxt = o_ready_flag ? 8'h00 : low_cnt_nxt;
        wr_age_nxt = (wr_age_r == 8'hff) ? 8'hff : wr_age_r + 8'h01;
        wr_age_nxt = i_wr_n ? wr_age_nxt : 8'h00;
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            low_cnt_r <= 8'h00;
            wr_age_r  <= 8'hff;
        end else begin
            low_cnt_r <= low_cnt_nxt;
            wr_age_r  <= wr_age_nxt;
        end
    end
    sequence busy_start;
        $fell(o_ready_flag);
    endsequence
    sequence entry_pins_zero;
        !(i_page_latch_strobe || i_action_select_hi ||
          i_action_select_lo || i_byte_select_a);
    endsequence
    prog_oe_a: assert property (!o_data_oe_n |-> o_prog_mode)
        else $error("bus driven outside programming mode");
    oe_idle_a: assert property (i_oe_n [*4] |-> o_data_oe_n)
        else $error("bus driven while output enable high");
    exit_mode_a: assert property (!i_prog_voltage [*4] |-> !o_prog_mode)
        else $error("programming mode kept without high voltage");
    ready_mode_a: assert property (!o_ready_flag |-> o_prog_mode)
        else $error("busy outside programming mode");
    busy_min_a: assert property ($rose(o_ready_flag) |->
        low_cnt_r == BUSY_CYC)
        else $error("busy period length wrong");
    busy_max_a: assert property (!o_ready_flag |->
        low_cnt_r < BUSY_CYC)
        else $error("busy period too long");
    wr_cause_a: assert property (busy_start |-> wr_age_r < 8'h0c)
        else $error("busy without commit strobe");
    entry_pins_a: assert property ($rose(o_prog_mode) |->
        !$past(i_page_latch_strobe, 3) && !$past(i_action_select_hi, 3) &&
        !$past(i_action_select_lo, 3) && !$past(i_byte_select_a, 3))
        else $error("mode entered with entry pins not zero");
    entry_c: cover property (entry_pins_zero ##1 $rose(o_prog_mode));
endmodule : ppp_port_monitor
bind ppp_port ppp_port_monitor #(.BUSY_CYC(BUSY_CYC)) i_ppp_port_monitor (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_prog_voltage(i_prog_voltage),
    .i_action_select_hi(i_action_select_hi),
    .i_action_select_lo(i_action_select_lo),
    .i_byte_select_a(i_byte_select_a),
    .i_page_latch_strobe(i_page_latch_strobe), .i_wr_n(i_wr_n),
    .i_oe_n(i_oe_n), .o_data_oe_n(o_data_oe_n),
    .o_ready_flag(o_ready_flag), .o_prog_mode(o_prog_mode));

// file: bench/ppp_programmer.sv
`timescale 1ns/1ps
module ppp_programmer (
    input  wire logic       i_clk_sys,
    input  wire logic       i_ready_flag,
    input  wire logic [7:0] i_bus,
    output logic            o_prog_voltage = 1'b0,
    output logic            o_load_strobe_clock = 1'b0,
    output logic            o_action_select_hi = 1'b0,
    output logic            o_action_select_lo = 1'b0,
    output logic            o_byte_select_a = 1'b0,
    output logic            o_byte_select_b = 1'b0,
    output logic            o_page_latch_strobe = 1'b0,
    output logic            o_wr_n = 1'b1,
    output logic            o_oe_n = 1'b1,
    output logic      [7:0] o_data = 8'h00
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick
    task automatic enter(input logic bump);
        o_prog_voltage = 1'b0;
        for (int k = 0; k < 12; k++) begin
            o_load_strobe_clock = ~o_load_strobe_clock;
            tick(2);
        end
        tick(3); // Entry pins left as they are: 0000 on the first entry, action select 10 on the second
        o_prog_voltage = 1'b1;
        if (bump) begin
            tick(1);
            o_page_latch_strobe = 1'b1; // Change inside settle time
        end
        tick(10); // Pins kept still after high voltage
        o_page_latch_strobe = 1'b0;
    endtask : enter
    task automatic leave;
        o_prog_voltage = 1'b0;
        tick(6);
    endtask : leave
    task automatic load(input logic [1:0] act, input logic bsa,
                        input logic [7:0] d);
        {o_action_select_hi, o_action_select_lo} = act;
        o_byte_select_a = bsa;
        o_data = d;
        tick(4);
        o_load_strobe_clock = 1'b1;
        tick(4);
        o_load_strobe_clock = 1'b0;
        tick(4);
    endtask : load
    task automatic latch;
        o_page_latch_strobe = 1'b1;
        tick(4);
        o_page_latch_strobe = 1'b0;
        tick(4);
    endtask : latch
    task automatic commit(input logic bsb, input logic bsa, output logic busy);
        o_byte_select_b = bsb;
        o_byte_select_a = bsa;
        tick(4);
        o_wr_n = 1'b0;
        busy = 1'b0;
        for (int k = 0; k < 8; k++) begin
            tick(1);
            busy = busy | (i_ready_flag === 1'b0);
        end
        o_wr_n = 1'b1;
        for (int k = 0; k < 300 && i_ready_flag !== 1'b1; k++) begin
            tick(1);
        end
        o_byte_select_b = 1'b0;
        tick(4);
    endtask : commit
    task automatic rd(input logic bsb, input logic bsa, output logic [7:0] v);
        o_byte_select_b = bsb;
        o_byte_select_a = bsa;
        // Released bus shows a changed value, never the last one
        o_data = ~o_data;
        o_oe_n = 1'b0;
        tick(6);
        v = i_bus;
        o_oe_n = 1'b1;
        tick(4);
    endtask : rd
endmodule : ppp_programmer

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys;
    logic rst = 1'b1;
    logic pv, lsc, ahi, alo, bsa, bsb, pls, wr_n, oe_n, doe_n, rdy, pmode;
    logic [7:0] pd;
    logic [7:0] dd;
    wire  [7:0] bus = doe_n ? pd : dd;
    int n_fail = 0;
    int tests_run = 0;
    localparam logic [31:0] ROWS [8] = '{32'h04_00_00_e1, 32'h04_00_03_99,
        32'h04_00_02_fd, 32'h04_00_01_ff, 32'h08_00_00_5a, 32'h08_01_00_3c,
        32'h08_02_00_11, 32'h08_00_01_80};
    ppp_port #(.BUSY_CYC(16)) i_ppp_port (.i_clk_sys(clk_sys), .i_rst(rst),
        .i_prog_voltage(pv), .i_load_strobe_clock(lsc),
        .i_action_select_hi(ahi), .i_action_select_lo(alo),
        .i_byte_select_a(bsa), .i_byte_select_b(bsb),
        .i_page_latch_strobe(pls), .i_wr_n(wr_n), .i_oe_n(oe_n),
        .i_data(bus), .o_data(dd), .o_data_oe_n(doe_n),
        .o_ready_flag(rdy), .o_prog_mode(pmode));
    ppp_programmer i_ppp_programmer (.i_clk_sys(clk_sys), .i_ready_flag(rdy),
        .i_bus(bus), .o_prog_voltage(pv), .o_load_strobe_clock(lsc),
        .o_action_select_hi(ahi), .o_action_select_lo(alo),
        .o_byte_select_a(bsa), .o_byte_select_b(bsb),
        .o_page_latch_strobe(pls), .o_wr_n(wr_n), .o_oe_n(oe_n),
        .o_data(pd));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        i_ppp_programmer.load(a, b, d);
    endtask : ld
    task automatic rdc(input logic bb, input logic ba, input logic [7:0] e);
        logic [7:0] v;
        i_ppp_programmer.rd(bb, ba, v);
        chk(v, e);
    endtask : rdc
    // Watchdog sized well beyond the roughly one thousand cycles the tests need
    initial begin
        #(40 * 20000);
        n_fail++;
        finish_test();
    end
    initial begin
        logic busy;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({5'h0, rdy, pmode, doe_n}, 8'h05);
        rst = 1'b0;
        i_ppp_programmer.enter(1'b0);
        chk({7'h0, pmode}, 8'h01);
        $display("test entry done");
        for (int r = 0; r < 8; r++) begin
            ld(2'b10, 1'b0, ROWS[r][31:24]);
            ld(2'b00, 1'b0, ROWS[r][23:16]);
            rdc(ROWS[r][9], ROWS[r][8], ROWS[r][7:0]);
        end
        $display("test read table done");
        ld(2'b10, 1'b0, 8'h10);
        ld(2'b00, 1'b1, 8'h00);
        ld(2'b00, 1'b0, 8'h05);
        ld(2'b01, 1'b0, 8'ha5);
        ld(2'b01, 1'b1, 8'h3c);
        i_ppp_programmer.latch();
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        chk({7'h0, busy}, 8'h01);
        ld(2'b10, 1'b0, 8'h00);
        ld(2'b10, 1'b0, 8'h02); // Address kept from before
        rdc(1'b0, 1'b0, 8'ha5);
        rdc(1'b0, 1'b1, 8'h3c);
        ld(2'b10, 1'b0, 8'h10);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        chk({7'h0, busy}, 8'h00); // No page latched after no-op
        $display("test flash done");
        ld(2'b10, 1'b0, 8'h11);
        ld(2'b00, 1'b0, 8'h09);
        ld(2'b01, 1'b0, 8'h77);
        i_ppp_programmer.latch();
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        chk({7'h0, busy}, 8'h01);
        ld(2'b10, 1'b0, 8'h03);
        rdc(1'b0, 1'b0, 8'h77);
        ld(2'b11, 1'b0, 8'h02); // Idle action loads nothing
        rdc(1'b0, 1'b0, 8'h77);
        $display("test eeprom done");
        ld(2'b10, 1'b0, 8'h40);
        ld(2'b01, 1'b0, 8'h98);
        i_ppp_programmer.commit(1'b0, 1'b1, busy);
        ld(2'b10, 1'b0, 8'h04);
        rdc(1'b1, 1'b1, 8'h98);
        ld(2'b10, 1'b0, 8'h20);
        ld(2'b01, 1'b0, 8'hfc);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        ld(2'b10, 1'b0, 8'h04);
        rdc(1'b0, 1'b1, 8'hfc);
        ld(2'b10, 1'b0, 8'h40);
        ld(2'b01, 1'b0, 8'h00);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        chk({7'h0, busy}, 8'h00); // Locked fuses refuse
        ld(2'b10, 1'b0, 8'h04);
        rdc(1'b0, 1'b0, 8'he1);
        $display("test fuse lock done");
        ld(2'b10, 1'b0, 8'h80);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        chk({7'h0, busy}, 8'h01);
        ld(2'b10, 1'b0, 8'h04);
        rdc(1'b0, 1'b1, 8'hff);
        rdc(1'b1, 1'b1, 8'h98); // Fuses survive erase
        ld(2'b10, 1'b0, 8'h02);
        rdc(1'b0, 1'b0, 8'hff);
        ld(2'b10, 1'b0, 8'h03);
        rdc(1'b0, 1'b0, 8'h77); // Keep-EEPROM fuse programmed
        ld(2'b10, 1'b0, 8'h40);
        ld(2'b01, 1'b0, 8'he9);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        ld(2'b10, 1'b0, 8'h04);
        rdc(1'b0, 1'b0, 8'he9); // Fuses writable after erase
        ld(2'b10, 1'b0, 8'h80);
        i_ppp_programmer.commit(1'b0, 1'b0, busy);
        ld(2'b10, 1'b0, 8'h03);
        rdc(1'b0, 1'b0, 8'hff); // Keep-EEPROM fuse unprogrammed
        $display("test erase done");
        i_ppp_programmer.leave();
        chk({7'h0, pmode}, 8'h00);
        i_ppp_programmer.enter(1'b1);
        chk({7'h0, pmode}, 8'h00); // Entry fails, action select still 10
        $display("test exit done");
        finish_test();
    end
endmodule : tb_top

// file: logic/ppp_params.svh
`ifndef PPP_PARAMS_SVH
`define PPP_PARAMS_SVH
`define PPP_CMD_NOP        8'h00
`define PPP_CMD_ERASE      8'h80
`define PPP_CMD_WR_FUSE    8'h40
`define PPP_CMD_WR_LOCK    8'h20
`define PPP_CMD_WR_FLASH   8'h10
`define PPP_CMD_WR_EE      8'h11
`define PPP_CMD_RD_SIG     8'h08
`define PPP_CMD_RD_FUSE    8'h04
`define PPP_CMD_RD_FLASH   8'h02
`define PPP_CMD_RD_EE      8'h03
`define PPP_ENTRY_CLOCKS   6
`define PPP_SETTLE_NS      100
`define PPP_CLK_NS         40
`define PPP_SETTLE_CYC     ((`PPP_SETTLE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_FUSE_LO_RST    8'he1
`define PPP_FUSE_HI_RST    8'h99
`define PPP_FUSE_EXT_RST   8'hfd
`define PPP_LOCK_RST       8'hff
`define PPP_KEEP_EE_BIT    3
`define PPP_BUSY_CYC       64
`endif

// file: logic/ppp_pkg.sv
package ppp_pkg;
    typedef enum logic [1:0] {
        ACT_ADDR = 2'b00,
        ACT_DATA = 2'b01,
        ACT_CMD  = 2'b10,
        ACT_IDLE = 2'b11
    } ppp_action_t;
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_ARM    = 3'b001,
        ST_SETTLE = 3'b010,
        ST_READY  = 3'b011,
        ST_BUSY   = 3'b100
    } ppp_state_t;
endpackage : ppp_pkg

// file: logic/ppp_port.sv
`timescale 1ns/1ps
`include "ppp_params.svh"
// Operation
// - Entry pin change within 100 ns after high voltage aborts entry.
// - Fuses locked while lock bits programmed, until chip erase.
// - Leave programming mode on power down or reset low.
// - Command and address held across operations; high byte reload optional.
// - Chip erase clears flash, EEPROM, locks; fuses kept; locks last (here locks clear in the same cycle as flash and EEPROM).
// - Keep-EEPROM fuse programmed makes chip erase spare EEPROM.
// - Command 80 then commit strobe starts chip erase; ready drops.
// - Action 01 loads data low or high byte by byte select A.
// - Action 00 loads address low or high byte by byte select A.
// - Page latch strobe copies data bytes into buffer at address word.
// - Low address bits pick word in page, higher bits pick page.
// - Commit strobe with select A low programs buffered page; ready drops.
// - No-operation command ends page programming, clears write state.
// - Command 11 writes EEPROM page through buffer and commit strobe.
// - Command 02 reads flash low/high byte by select A while OE low.
// - Command 03 reads addressed EEPROM byte while OE low.
// - Command 40 writes fuse low/high/extended chosen by byte selects.
// - Command 20 programs lock bits where data is zero; erase clears.
// - Command 04 reads fuses or locks chosen by byte selects.
// - Command 08 reads signature by address or calibration byte.
// - Action select: 00 address, 01 data, 10 command, 11 nothing.
// - Ready flag low while busy, high when ready.
// - Data bus driven only while output enable is low.
module ppp_port #(
    parameter int          FLASH_AW  = 16,
    parameter int          EE_AW     = 12,
    parameter int          FPAGE_W   = 7,
    parameter int          EPAGE_W   = 3,
    parameter int          BUSY_CYC  = `PPP_BUSY_CYC,
    parameter logic [7:0]  SIG0      = 8'h5a,  // Arbitrary identity value
    parameter logic [7:0]  SIG1      = 8'h3c,  // Arbitrary identity value
    parameter logic [7:0]  SIG2      = 8'h11,  // Arbitrary identity value
    parameter logic [7:0]  CALIB     = 8'h80
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_prog_voltage,
    input  wire logic       i_load_strobe_clock,
    input  wire logic       i_action_select_hi,
    input  wire logic       i_action_select_lo,
    input  wire logic       i_byte_select_a,
    input  wire logic       i_byte_select_b,
    input  wire logic       i_page_latch_strobe,
    input  wire logic       i_wr_n,
    input  wire logic       i_oe_n,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe_n,
    output logic            o_ready_flag,
    output logic            o_prog_mode
);
    localparam int SETTLE = (`PPP_SETTLE_CYC < 1) ? 1 : `PPP_SETTLE_CYC;
    localparam int FW = 1 << FLASH_AW;
    localparam int EW = 1 << EE_AW;

    // All pins arrive from outside the clock domain, so each is synchronised first
    logic [8:0] pin_s;
    ppp_sync #(.W(9)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_prog_voltage, i_load_strobe_clock, i_action_select_hi,
                     i_action_select_lo, i_byte_select_a, i_byte_select_b,
                     i_page_latch_strobe, i_wr_n, i_oe_n}),
        .o_sync    (pin_s)
    );
    logic hv, lsc, bsa, bsb, pgl, wrn, oen;
    ppp_pkg::ppp_action_t act;
    assign hv  = pin_s[8];
    assign lsc = pin_s[7];
    assign act = ppp_pkg::ppp_action_t'(pin_s[6:5]);
    assign bsa = pin_s[4];
    assign bsb = pin_s[3];
    assign pgl = pin_s[2];
    assign wrn = pin_s[1];
    assign oen = pin_s[0];
    logic [7:0] d1_r, d2_r;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            d1_r <= 8'h00;
            d2_r <= 8'h00;
        end else begin
            d1_r <= i_data;
            d2_r <= d1_r;
        end
    end

    // Memories
    logic [15:0] flash_m [FW];
    logic [7:0]  ee_m    [EW];
    logic [15:0] fbuf_m  [1 << FPAGE_W];
    logic [7:0]  ebuf_m  [1 << EPAGE_W];

    ppp_pkg::ppp_state_t st_r, st_nxt;
    logic [7:0]  cmd_r, cmd_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] dat_r, dat_nxt;
    logic [7:0]  flo_r, flo_nxt, fhi_r, fhi_nxt, fex_r, fex_nxt;
    logic [7:0]  lock_r, lock_nxt;
    logic [2:0]  tog_r, tog_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0]  busy_cmd_r, busy_cmd_nxt;
    logic        lsc_q_r, pgl_q_r, wrn_q_r, bsa_entry_r;
    logic        pgm_ok_r, pgm_ok_nxt;
    logic        lsc_rise, pgl_rise, wr_fall, entry_pins_zero;

    assign lsc_rise = lsc & ~lsc_q_r;
    assign pgl_rise = pgl & ~pgl_q_r;
    assign wr_fall  = ~wrn & wrn_q_r;
    assign entry_pins_zero = ~pgl & (act == ppp_pkg::ACT_ADDR) & ~bsa;

    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        dat_nxt = dat_r;
        flo_nxt = flo_r;
        fhi_nxt = fhi_r;
        fex_nxt = fex_r;
        lock_nxt = lock_r;
        tog_nxt = tog_r;
        cnt_nxt = cnt_r;
        busy_cmd_nxt = busy_cmd_r;
        pgm_ok_nxt = pgm_ok_r;
        unique case (st_r)
            ppp_pkg::ST_OFF: begin
                if (lsc_rise && tog_r < 3'(`PPP_ENTRY_CLOCKS))
                    tog_nxt = tog_r + 3'd1;
                if (hv && tog_r >= 3'(`PPP_ENTRY_CLOCKS) && entry_pins_zero)
                begin
                    st_nxt = ppp_pkg::ST_SETTLE;
                    cnt_nxt = 16'h0000;
                end
            end
            ppp_pkg::ST_SETTLE: begin
                if (!entry_pins_zero) begin
                    st_nxt = ppp_pkg::ST_ARM;
                end else if (cnt_r >= 16'(SETTLE)) begin
                    st_nxt = ppp_pkg::ST_READY;
                    cmd_nxt = `PPP_CMD_NOP;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            ppp_pkg::ST_ARM: ;  // Failed entry waits for reset drop
            ppp_pkg::ST_READY: begin
                if (lsc_rise) begin
                    unique case (act)
                        ppp_pkg::ACT_ADDR:
                            if (bsa) addr_nxt[15:8] = d2_r;
                            else addr_nxt[7:0] = d2_r;
                        ppp_pkg::ACT_DATA:
                            if (bsa) dat_nxt[15:8] = d2_r;
                            else dat_nxt[7:0] = d2_r;
                        ppp_pkg::ACT_CMD: begin
                            cmd_nxt = d2_r;
                            if (d2_r == `PPP_CMD_NOP)
                                pgm_ok_nxt = 1'b0;
                        end
                        ppp_pkg::ACT_IDLE: ;
                    endcase
                end
                if (pgl_rise)
                    pgm_ok_nxt = 1'b1;  // Set wins over no-op clear
                if (wr_fall) begin
                    unique case (cmd_r)
                        `PPP_CMD_ERASE, `PPP_CMD_WR_FLASH, `PPP_CMD_WR_EE:
                        begin
                            if (cmd_r == `PPP_CMD_ERASE ||
                                (!bsa && pgm_ok_r)) begin
                                st_nxt = ppp_pkg::ST_BUSY;
                                busy_cmd_nxt = cmd_r;
                                cnt_nxt = 16'h0000;
                            end
                        end
                        `PPP_CMD_WR_FUSE:
                            if (lock_r[1:0] == 2'b11) begin
                                st_nxt = ppp_pkg::ST_BUSY;
                                busy_cmd_nxt = cmd_r;
                                cnt_nxt = 16'h0000;
                                if (bsb) fex_nxt = dat_r[7:0];
                                else if (bsa) fhi_nxt = dat_r[7:0];
                                else flo_nxt = dat_r[7:0];
                            end
                        `PPP_CMD_WR_LOCK: begin
                            lock_nxt = lock_r & dat_r[7:0];
                            st_nxt = ppp_pkg::ST_BUSY;
                            busy_cmd_nxt = cmd_r;
                            cnt_nxt = 16'h0000;
                        end
                        default: ;
                    endcase
                end
            end
            ppp_pkg::ST_BUSY: begin
                if (cnt_r >= 16'(BUSY_CYC - 1)) begin
                    st_nxt = ppp_pkg::ST_READY;
                    if (busy_cmd_r == `PPP_CMD_ERASE)
                        lock_nxt = `PPP_LOCK_RST;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: st_nxt = ppp_pkg::ST_OFF;
        endcase
        if (!hv && st_r != ppp_pkg::ST_OFF) begin
            st_nxt = ppp_pkg::ST_OFF;
            tog_nxt = 3'd0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_r <= ppp_pkg::ST_OFF;
            cmd_r <= `PPP_CMD_NOP;
            addr_r <= 16'h0000;
            dat_r <= 16'hffff;
            flo_r <= `PPP_FUSE_LO_RST;
            fhi_r <= `PPP_FUSE_HI_RST;
            fex_r <= `PPP_FUSE_EXT_RST;
            lock_r <= `PPP_LOCK_RST;
            tog_r <= 3'd0;
            cnt_r <= 16'h0000;
            busy_cmd_r <= `PPP_CMD_NOP;
            pgm_ok_r <= 1'b0;
            lsc_q_r <= 1'b0;
            pgl_q_r <= 1'b0;
            wrn_q_r <= 1'b0;  // Matches synchroniser reset, no false fall
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            dat_r <= dat_nxt;
            flo_r <= flo_nxt;
            fhi_r <= fhi_nxt;
            fex_r <= fex_nxt;
            lock_r <= lock_nxt;
            tog_r <= tog_nxt;
            cnt_r <= cnt_nxt;
            busy_cmd_r <= busy_cmd_nxt;
            pgm_ok_r <= pgm_ok_nxt;
            lsc_q_r <= lsc;
            pgl_q_r <= pgl;
            wrn_q_r <= wrn;
        end
    end

    // Arrays carry no reset; contents model nonvolatile cells
    logic       rdy, fin;
    logic [FPAGE_W-1:0] fword;
    logic [EPAGE_W-1:0] eword;
    assign rdy   = (st_r == ppp_pkg::ST_READY);
    assign fin   = (st_r == ppp_pkg::ST_BUSY) && (cnt_r >= 16'(BUSY_CYC - 1));
    assign fword = addr_r[FPAGE_W-1:0];
    assign eword = addr_r[EPAGE_W-1:0];
    always_ff @(posedge i_clk_sys) begin
        if (rdy && pgl_rise) begin
            if (cmd_r == `PPP_CMD_WR_EE) ebuf_m[eword] <= dat_r[7:0];
            else fbuf_m[fword] <= dat_r;
        end
        if (fin) begin
            for (int i = 0; i < FW; i++)
                if (busy_cmd_r == `PPP_CMD_ERASE) flash_m[i] <= 16'hffff;
            for (int i = 0; i < EW; i++)
                if (busy_cmd_r == `PPP_CMD_ERASE && flo_r[`PPP_KEEP_EE_BIT])
                    ee_m[i] <= 8'hff;
            if (busy_cmd_r == `PPP_CMD_WR_FLASH)
                for (int i = 0; i < (1 << FPAGE_W); i++)
                    flash_m[{addr_r[FLASH_AW-1:FPAGE_W],
                             FPAGE_W'(i)}] <= fbuf_m[i];
            if (busy_cmd_r == `PPP_CMD_WR_EE)
                for (int i = 0; i < (1 << EPAGE_W); i++)
                    ee_m[{addr_r[EE_AW-1:EPAGE_W],
                          EPAGE_W'(i)}] <= ebuf_m[i];
        end
    end

    // Read path
    logic [7:0] rd_nxt, rd_r;
    logic [15:0] fw_rd;
    assign fw_rd = flash_m[addr_r[FLASH_AW-1:0]];
    always_comb begin
        rd_nxt = 8'hff;
        unique case (cmd_r)
            `PPP_CMD_RD_FLASH: rd_nxt = bsa ? fw_rd[15:8] : fw_rd[7:0];
            `PPP_CMD_RD_EE:    rd_nxt = ee_m[addr_r[EE_AW-1:0]];
            `PPP_CMD_RD_FUSE:
                unique case ({bsb, bsa})
                    2'b00:   rd_nxt = flo_r;
                    2'b11:   rd_nxt = fhi_r;
                    2'b10:   rd_nxt = fex_r;
                    default: rd_nxt = lock_r;
                endcase
            `PPP_CMD_RD_SIG:
                if (bsa) rd_nxt = CALIB;
                else if (addr_r[1:0] == 2'd0) rd_nxt = SIG0;
                else if (addr_r[1:0] == 2'd1) rd_nxt = SIG1;
                else rd_nxt = SIG2;
            default: rd_nxt = 8'hff;
        endcase
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) rd_r <= 8'h00;
        else rd_r <= rd_nxt;
    end

    assign o_data       = rd_r;
    assign o_data_oe_n  = ~(rdy & ~oen);
    assign o_ready_flag = (st_r != ppp_pkg::ST_BUSY);
    assign o_prog_mode  = rdy | (st_r == ppp_pkg::ST_BUSY);
endmodule : ppp_port

// file: logic/ppp_sync.sv
`timescale 1ns/1ps
module ppp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;
endmodule : ppp_sync
